// File: pcc_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts for the PLL clock control block.
// Assumes: Wishbone byte addresses on a 32-bit data bus, one register per aligned word.
// Notes: Definitions only.
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

// ==========================================================================
// Register offsets
`define PCC_OFF_CTRL 4'h0
`define PCC_OFF_IRQ_STATUS 4'h4
`define PCC_OFF_IRQ_MASK 4'h8
`define PCC_OFF_FREQ 4'hC

// ==========================================================================
// Control register fields and reset value
`define PCC_CTRL_RESET 16'h3F00
`define PCC_CTRL_WMASK 16'hFF87
`define PCC_BIT_VCO_X4 15
`define PCC_BIT_PRESCALE 14
`define PCC_MOD_HI 13
`define PCC_MOD_LO 8
`define PCC_BIT_BUSDIV 7
`define PCC_BIT_LIMP 4
`define PCC_BIT_LOCK 3
`define PCC_BIT_LOSS_RST 2
`define PCC_BIT_STOP_INT 1
`define PCC_BIT_STOP_OUT 0

// ==========================================================================
// Interrupt status and mask bits
`define PCC_IRQ_W 3
`define PCC_IRQ_LIMP 0
`define PCC_IRQ_LOCK_UP 1
`define PCC_IRQ_LOCK_DOWN 2

// ==========================================================================
// Timing
`define PCC_CLK_MHZ 10
`define PCC_SAMPLE_NS 800
`define PCC_SAMPLE_CYC ((`PCC_SAMPLE_NS * `PCC_CLK_MHZ + 999) / 1000)
`define PCC_BUSDIV_HALF_SLOW 4'd8
`define PCC_BUSDIV_HALF_FAST 4'd4
`define PCC_REF_SHIFT 3'd2

`endif

// File: pcc_pkg.sv
// Purpose: Types shared by the PLL clock control block.
// Assumes: Constants live in pcc_defines.svh.
// Notes: Nothing here is imported; users write pcc_pkg::name.
package pcc_pkg;

	// ==================================================================
	// Sequencer states
	typedef enum logic [1:0] {
		PCC_ST_SAMPLE = 2'b00,
		PCC_ST_WAIT = 2'b01,
		PCC_ST_RUN = 2'b10,
		PCC_ST_LOSS = 2'b11
	} pcc_state_t;

	// ==================================================================
	// Controls driven to the analog synthesizer
	typedef struct packed {
		logic bypass;
		logic vco_en;
		logic vco_x4;
		logic div2_en;
		logic [6:0] fb_div;
	} pcc_synth_t;

endpackage

// File: pcc_pll_clock_control.sv
// Purpose: Digital control and status for the on-chip clock synthesizer.
// Assumes: clk is the 10 MHz system clock; pins are asynchronous to it.
// Notes: The analog loop sits outside; it reports lock and reference loss.
// Function
// [R01] Feedback divider divides by modulus field plus one, field 0 to 63, relock needed.
// [R02] VCO speed bit switches feedback prescaler tap for four times VCO speed, relock needed.
// [R03] Prescale bit controls divide-by-two outside the loop, doubles clock, no relock.
// [R04] System multiple is 4 times (modulus+1) times 2^(2W+X); VCO multiple times (2-X).
// [R05] Control register resets to modulus 63, speed bits clear, 256 times reference.
// [R06] Clock mode pin sampled high at reset selects synthesizer; upper byte sets frequency.
// [R07] Mode pin sampled low disables synthesizer, external clock used, frequency bits ignored.
// [R08] Control register reads and writes only from supervisor accesses.
// [R09] Peripheral bus clock is system clock divided by 8 when clear, 16 when set.
// [R10] Reference loss in synthesizer mode sets limp flag; VCO keeps running on base voltage.
// [R11] Limp clock stays within limit and prescale bit still applies its divide-by-two.
// [R12] Loss reset enable selects limp operation when clear, system reset when set.
// [R13] Device holds itself in reset after power-up until synthesizer reports lock.
// [R14] Lock flag is one when locked or external; true status only after first write.
// [R15] In stop, integration clock from crystal with VCO off when clear, from VCO when set.
// [R16] In stop, clock output held negated when clear, carries integration clock when set.
// [R17] Limp and lock flags read-only; relock-needing writes clear lock flag until lock.
// [R18] Control bits 6 and 5 read zero and ignore writes.
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.svh"

module pcc_pll_clock_control (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_supervisor_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic clock_mode_pin,
	input wire logic ref_lost_pin,
	input wire logic pll_lock_pin,
	input wire logic sleep_instruction,
	output pcc_pkg::pcc_synth_t synth_ctrl,
	output logic relock_req,
	output logic sys_resetn_out,
	output logic peripheral_bus_clock,
	output logic clock_output_en,
	output logic integration_clk_from_vco,
	output logic irq
);

	// ==================================================================
	// Pin synchronisers: three stages, a change counts when stages two and three agree.
	logic [2:0] pin_vec;
	logic [2:0] pin_stable;
	assign pin_vec = {pll_lock_pin, ref_lost_pin, clock_mode_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic st_reg;
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					st_reg <= 1'b0;
				end else begin
					s1_reg <= pin_vec[gi];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						st_reg <= s3_reg;
					end
				end
			end
			assign pin_stable[gi] = st_reg;
		end
	endgenerate

	logic mode_st;
	logic ref_lost_st;
	logic lock_st;
	assign mode_st = pin_stable[0];
	assign ref_lost_st = pin_stable[1];
	assign lock_st = pin_stable[2];

	// ==================================================================
	// Bus decode
	function automatic logic adr_hit(input logic [3:0] adr, input logic [3:0] off);
		adr_hit = (adr == off);
	endfunction

	logic req;
	logic hit_ctrl;
	logic hit_stat;
	logic hit_mask;
	logic hit_freq;
	logic ctrl_wr;
	logic ctrl_user;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign hit_ctrl = adr_hit(wb_adr_i, `PCC_OFF_CTRL);
	assign hit_stat = adr_hit(wb_adr_i, `PCC_OFF_IRQ_STATUS);
	assign hit_mask = adr_hit(wb_adr_i, `PCC_OFF_IRQ_MASK);
	assign hit_freq = adr_hit(wb_adr_i, `PCC_OFF_FREQ);
	// User-mode accesses to the control word are acknowledged but have no effect.
	assign ctrl_user = hit_ctrl && !wb_supervisor_i; // see [R08]
	assign ctrl_wr = req && wb_we_i && hit_ctrl && wb_supervisor_i; // see [R08]

	// ==================================================================
	// Registers and state
	pcc_pkg::pcc_state_t state_reg;
	pcc_pkg::pcc_state_t state_next;
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	logic [3:0] sample_cnt_reg;
	logic pll_mode_reg;
	logic written_reg;
	logic relock_pend_reg;
	logic lock_prev_reg;
	logic limp_flag_reg;
	logic lock_flag_reg;
	logic [`PCC_IRQ_W-1:0] irq_stat_reg;
	logic [`PCC_IRQ_W-1:0] irq_mask_reg;
	logic [3:0] bus_cnt_reg;

	// ==================================================================
	// Control word write path
	logic [15:0] byte_mask;
	logic [15:0] wr_mask;
	logic [15:0] ctrl_wr_val;
	logic relock_set;
	logic lock_rise;
	assign byte_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	// Flag and unused positions are outside the writable mask.
	assign wr_mask = `PCC_CTRL_WMASK & byte_mask; // see [R17] see [R18]
	assign ctrl_wr_val = (ctrl_reg & ~wr_mask) | (wb_dat_i[15:0] & wr_mask);
	assign ctrl_next = (state_reg == pcc_pkg::PCC_ST_LOSS) ? `PCC_CTRL_RESET :
		(ctrl_wr ? ctrl_wr_val : ctrl_reg);
	// Only the VCO speed and modulus fields disturb the loop; the prescale bit does not.
	assign relock_set = ctrl_wr && pll_mode_reg &&
		((ctrl_wr_val[`PCC_BIT_VCO_X4] != ctrl_reg[`PCC_BIT_VCO_X4]) ||
		(ctrl_wr_val[`PCC_MOD_HI:`PCC_MOD_LO] != ctrl_reg[`PCC_MOD_HI:`PCC_MOD_LO])); // see [R01] see [R02] see [R03]
	assign lock_rise = lock_st && !lock_prev_reg;

	// ==================================================================
	// Status flags
	logic limp_now;
	logic loss_rst_en;
	logic lock_next;
	logic limp_next;
	assign loss_rst_en = ctrl_reg[`PCC_BIT_LOSS_RST];
	assign limp_now = pll_mode_reg && ref_lost_st; // see [R10]
	// An external clock reads locked once the mode is known; in synthesizer mode the flag reads zero before the first write.
	assign lock_next = (state_reg != pcc_pkg::PCC_ST_SAMPLE) && (!pll_mode_reg ||
		(written_reg && lock_st && !relock_pend_reg && !ref_lost_st)); // see [R14] see [R17]
	assign limp_next = limp_now && (state_reg == pcc_pkg::PCC_ST_RUN) && !loss_rst_en; // see [R10] see [R12]

	// ==================================================================
	// Sequencer
	logic sample_done;
	assign sample_done = (sample_cnt_reg == 4'(`PCC_SAMPLE_CYC - 1));

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			pcc_pkg::PCC_ST_SAMPLE: begin
				if (sample_done) begin
					state_next = pcc_pkg::PCC_ST_WAIT;
				end
			end
			pcc_pkg::PCC_ST_WAIT: begin
				if (!pll_mode_reg || (lock_st && !ref_lost_st)) begin // see [R13]
					state_next = pcc_pkg::PCC_ST_RUN;
				end
			end
			pcc_pkg::PCC_ST_RUN: begin
				if (limp_now && loss_rst_en) begin // see [R12]
					state_next = pcc_pkg::PCC_ST_LOSS;
				end
			end
			pcc_pkg::PCC_ST_LOSS: begin
				state_next = pcc_pkg::PCC_ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= pcc_pkg::PCC_ST_SAMPLE;
			sample_cnt_reg <= 4'h0;
			sys_resetn_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (!sample_done && state_reg == pcc_pkg::PCC_ST_SAMPLE) begin
				sample_cnt_reg <= sample_cnt_reg + 4'h1;
			end
			sys_resetn_out <= (state_next == pcc_pkg::PCC_ST_RUN); // see [R13]
		end
	end

	// The mode pin is caught by the clock after reset release, once the synchroniser has settled.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pll_mode_reg <= 1'b0;
		end else if (state_reg == pcc_pkg::PCC_ST_SAMPLE && sample_done) begin
			pll_mode_reg <= mode_st; // see [R06] see [R07]
		end
	end

	// ==================================================================
	// Control and status registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg <= `PCC_CTRL_RESET; // see [R05]
			written_reg <= 1'b0;
			relock_pend_reg <= 1'b0;
			lock_prev_reg <= 1'b0;
			limp_flag_reg <= 1'b0;
			lock_flag_reg <= 1'b0;
			relock_req <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			written_reg <= written_reg || ctrl_wr; // see [R14]
			lock_prev_reg <= lock_st;
			// A new relock request wins over a lock edge seen in the same cycle.
			relock_pend_reg <= relock_set || (relock_pend_reg && !lock_rise); // see [R17]
			limp_flag_reg <= limp_next;
			lock_flag_reg <= lock_next;
			relock_req <= relock_set;
		end
	end

	// ==================================================================
	// Interrupts: sticky events, write one to clear, set beats clear.
	logic [`PCC_IRQ_W-1:0] irq_ev;
	logic [`PCC_IRQ_W-1:0] irq_clr;
	assign irq_ev[`PCC_IRQ_LIMP] = limp_next && !limp_flag_reg;
	assign irq_ev[`PCC_IRQ_LOCK_UP] = lock_next && !lock_flag_reg;
	assign irq_ev[`PCC_IRQ_LOCK_DOWN] = !lock_next && lock_flag_reg;
	assign irq_clr = (req && wb_we_i && hit_stat && wb_sel_i[0]) ? wb_dat_i[`PCC_IRQ_W-1:0] : '0;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
			if (req && wb_we_i && hit_mask && wb_sel_i[0]) begin
				irq_mask_reg <= wb_dat_i[`PCC_IRQ_W-1:0];
			end
			irq <= |(((irq_stat_reg & ~irq_clr) | irq_ev) & irq_mask_reg);
		end
	end

	// ==================================================================
	// Frequency multiples relative to the reference
	logic [11:0] sys_mult;
	logic [11:0] vco_mult;
	logic [2:0] mult_shift;
	assign mult_shift = `PCC_REF_SHIFT + {1'b0, ctrl_reg[`PCC_BIT_VCO_X4], 1'b0} +
		{2'b00, ctrl_reg[`PCC_BIT_PRESCALE]};
	assign sys_mult = (12'(ctrl_reg[`PCC_MOD_HI:`PCC_MOD_LO]) + 12'h001) << mult_shift; // see [R04]
	assign vco_mult = ctrl_reg[`PCC_BIT_PRESCALE] ? sys_mult : (sys_mult << 1); // see [R04]

	// ==================================================================
	// Read path
	logic [15:0] ctrl_read;
	logic [31:0] rd_word;
	// Bits 6 and 5 are not stored and read back as zero.
	assign ctrl_read = (ctrl_reg & `PCC_CTRL_WMASK) |
		(16'(limp_flag_reg) << `PCC_BIT_LIMP) | (16'(lock_flag_reg) << `PCC_BIT_LOCK); // see [R17] see [R18]
	assign rd_word = (hit_ctrl && !ctrl_user) ? {16'h0000, ctrl_read} :
		hit_stat ? {29'h0, irq_stat_reg} :
		hit_mask ? {29'h0, irq_mask_reg} :
		hit_freq ? {4'h0, vco_mult, 4'h0, sys_mult} : 32'h0000_0000; // see [R08]

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (req && !wb_we_i) begin
				wb_dat_o <= rd_word;
			end
		end
	end

	// ==================================================================
	// Synthesizer drive, stop-mode clock gating
	logic stop_int_sel;
	logic stop_out_sel;
	logic vco_run;
	assign stop_int_sel = ctrl_reg[`PCC_BIT_STOP_INT];
	assign stop_out_sel = ctrl_reg[`PCC_BIT_STOP_OUT];
	// In limp mode the VCO keeps running on its base voltage; only stop can turn it off.
	assign vco_run = pll_mode_reg && !(sleep_instruction && !stop_int_sel); // see [R10] see [R15]

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			synth_ctrl <= '0;
			clock_output_en <= 1'b0;
			integration_clk_from_vco <= 1'b0;
		end else begin
			synth_ctrl.bypass <= !pll_mode_reg; // see [R07]
			synth_ctrl.vco_en <= vco_run; // see [R15]
			synth_ctrl.vco_x4 <= pll_mode_reg && ctrl_reg[`PCC_BIT_VCO_X4]; // see [R02]
			// Divide-by-two stays in force in limp mode.
			synth_ctrl.div2_en <= pll_mode_reg && !ctrl_reg[`PCC_BIT_PRESCALE]; // see [R03] see [R11]
			synth_ctrl.fb_div <= 7'(ctrl_reg[`PCC_MOD_HI:`PCC_MOD_LO]) + 7'h01; // see [R01]
			clock_output_en <= !sleep_instruction || stop_out_sel; // see [R16]
			integration_clk_from_vco <= vco_run; // see [R15]
		end
	end

	// ==================================================================
	// Peripheral bus clock: a registered square wave at clk/8 or clk/16.
	logic [3:0] bus_half;
	logic bus_wrap;
	assign bus_half = ctrl_reg[`PCC_BIT_BUSDIV] ? `PCC_BUSDIV_HALF_SLOW : `PCC_BUSDIV_HALF_FAST; // see [R09]
	assign bus_wrap = (bus_cnt_reg >= bus_half - 4'h1);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus_cnt_reg <= 4'h0;
			peripheral_bus_clock <= 1'b0;
		end else begin
			bus_cnt_reg <= bus_wrap ? 4'h0 : bus_cnt_reg + 4'h1;
			if (bus_wrap) begin
				peripheral_bus_clock <= !peripheral_bus_clock; // see [R09]
			end
		end
	end

	// ==================================================================
	// Checks
	logic div_sel;
	assign div_sel = ctrl_reg[`PCC_BIT_BUSDIV];

	sequence s_loss_seen;
		state_reg == pcc_pkg::PCC_ST_RUN && limp_now && loss_rst_en;
	endsequence

	sequence s_relock_write;
		relock_set;
	endsequence

	a_ctrl_reset_val: assert property (@(posedge clk) disable iff (!resetn) // see [R05]
		(state_reg == pcc_pkg::PCC_ST_SAMPLE) |-> (ctrl_reg == 16'h3F00 && sys_mult == 12'h100))
		else $error("control word not at reset value during sampling");

	a_user_no_write: assert property (@(posedge clk) disable iff (!resetn) // see [R08]
		(req && wb_we_i && hit_ctrl && !wb_supervisor_i && state_reg != pcc_pkg::PCC_ST_LOSS) |=> $stable(ctrl_reg))
		else $error("user access altered the control word");

	a_unused_zero: assert property (@(posedge clk) disable iff (!resetn) // see [R18]
		(wb_ack_o && $past(hit_ctrl && wb_supervisor_i && !wb_we_i)) |-> (wb_dat_o[6:5] == 2'b00))
		else $error("unused control bits read nonzero");

	a_bus_div_eight: assert property (@(posedge clk) disable iff (!resetn) // see [R09]
		($rose(peripheral_bus_clock) && !div_sel) ##1 (!div_sel)[*7] |=> $rose(peripheral_bus_clock))
		else $error("bus clock period is not eight");

	a_bus_div_sixteen: assert property (@(posedge clk) disable iff (!resetn) // see [R09]
		($rose(peripheral_bus_clock) && div_sel) ##1 div_sel[*7] |=> !$rose(peripheral_bus_clock))
		else $error("bus clock period too short for sixteen");

	a_hold_reset: assert property (@(posedge clk) disable iff (!resetn) // see [R13]
		(state_reg == pcc_pkg::PCC_ST_WAIT && pll_mode_reg && !lock_st) |=> !sys_resetn_out)
		else $error("reset released before lock");

	a_loss_reset: assert property (@(posedge clk) disable iff (!resetn) // see [R12]
		s_loss_seen |=> ##[0:1] !sys_resetn_out)
		else $error("reference loss did not reset the system");

	a_limp_flag: assert property (@(posedge clk) disable iff (!resetn) // see [R10]
		(state_reg == pcc_pkg::PCC_ST_RUN && limp_now && !loss_rst_en) |=> (limp_flag_reg && synth_ctrl.vco_en == !$past(sleep_instruction && !stop_int_sel)))
		else $error("limp flag or VCO wrong on reference loss");

	a_stop_output: assert property (@(posedge clk) disable iff (!resetn) // see [R16]
		(sleep_instruction && !stop_out_sel) |=> !clock_output_en)
		else $error("clock output not held in stop");

	a_stop_integ: assert property (@(posedge clk) disable iff (!resetn) // see [R15]
		(sleep_instruction && !stop_int_sel) |=> (!synth_ctrl.vco_en && !integration_clk_from_vco))
		else $error("VCO not off in stop with crystal selected");

	a_relock_clear: assert property (@(posedge clk) disable iff (!resetn) // see [R17]
		s_relock_write |=> ##1 !lock_flag_reg)
		else $error("lock flag not cleared by relock write");

	a_prescale_out: assert property (@(posedge clk) disable iff (!resetn) // see [R03] see [R11]
		pll_mode_reg |=> (synth_ctrl.div2_en == !$past(ctrl_reg[`PCC_BIT_PRESCALE])))
		else $error("divide-by-two stage does not follow prescale bit");

	a_external_lock: assert property (@(posedge clk) disable iff (!resetn) // see [R07] see [R14]
		(!pll_mode_reg && state_reg == pcc_pkg::PCC_ST_RUN) |=> (lock_flag_reg && synth_ctrl.bypass))
		else $error("external clock mode not reported locked");

endmodule
`default_nettype wire

// File: pcc_analog_model.sv
// Purpose: Behavioural analog loop and reference source beside the clock control block.
// Assumes: The loop locks a fixed count after a relock request or after the reference returns.
// Notes: ref_fail is the bench's command to lose the reference.
`timescale 1ns/1ps
`default_nettype none
module pcc_analog_model #(
	parameter int LOCK_CYC = 30
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic relock_req,
	input wire logic ref_fail,
	output logic ref_lost_pin,
	output logic pll_lock_pin
);
	int cnt_reg;

	// ==================================================================
	// Lock timer
	// A prescale change does not unlock the loop; only a new feedback setting or a lost reference does.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= 0;
		end else if (relock_req || ref_fail) begin
			cnt_reg <= 0;
		end else if (cnt_reg < LOCK_CYC) begin
			cnt_reg <= cnt_reg + 1;
		end
	end
	assign pll_lock_pin = (cnt_reg == LOCK_CYC);
	assign ref_lost_pin = ref_fail;
endmodule
`default_nettype wire

// File: pcc_tb.sv
// Purpose: Self-checking bench for the PLL clock control block.
// Assumes: The analog loop is modelled with a short lock time.
// Notes: Each scenario task drives the block and judges the result itself.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.svh"
module tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sup = 1'b0, mode = 1'b1, ref_fail = 1'b0, sleep = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack, relock_req, sys_rstn, pbc, clock_output_pin_en, int_vco, irq, lock_pin, lost_pin;
	pcc_pkg::pcc_synth_t synth;
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	int relocks = 0;

	always #50 clk = ~clk;

	pcc_pll_clock_control i_pcc_pll_clock_control (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_supervisor_i(sup), .wb_dat_o(rdat),
		.wb_ack_o(ack), .clock_mode_pin(mode), .ref_lost_pin(lost_pin), .pll_lock_pin(lock_pin),
		.sleep_instruction(sleep), .synth_ctrl(synth), .relock_req(relock_req), .sys_resetn_out(sys_rstn),
		.peripheral_bus_clock(pbc), .clock_output_en(clock_output_pin_en), .integration_clk_from_vco(int_vco), .irq(irq));
	pcc_analog_model i_pcc_analog_model (.clk(clk), .resetn(resetn), .relock_req(relock_req),
		.ref_fail(ref_fail), .ref_lost_pin(lost_pin), .pll_lock_pin(lock_pin));

	// ==================================================================
	// Monitors and timeout
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (relock_req === 1'b1) begin
			relocks <= relocks + 1;
		end
		if (cycles == 20000) begin
			fail_count = fail_count + 1;
			report_and_stop();
		end
	end

	// ==================================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic s,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sup <= s;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		// The slave answers one cycle after it takes the request.
		chk(n, 2, "bus ack latency");
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 1'b1, q);
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, 1'b1, q);
	endtask

	task automatic wait_lock();
		int n;
		n = 0;
		while (lock_pin !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		repeat (8) @(posedge clk);
	endtask

	task automatic do_reset(input logic m);
		int n;
		@(posedge clk);
		resetn <= 1'b0;
		mode <= m;
		ref_fail <= 1'b0;
		sleep <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (15) @(posedge clk);
		if (m) begin
			chk(32'(sys_rstn), 32'h0, "held before lock");
		end
		n = 0;
		while (sys_rstn !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(32'(sys_rstn), 32'h1, "reset released");
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==================================================================
	// Scenarios
	task automatic t_access();
		logic [31:0] q;
		rd(`PCC_OFF_CTRL, q);
		chk(q, 32'h0000_3F00, "ctrl reset");
		chk(32'(synth), 32'h0000_02C0, "synth reset");
		rd(`PCC_OFF_FREQ, q);
		chk(q, 32'h0200_0100, "freq reset");
		bus(1'b1, `PCC_OFF_CTRL, 32'h0, 1'b0, q);
		bus(1'b0, `PCC_OFF_CTRL, 32'h0, 1'b0, q);
		chk(q, 32'h0, "user read");
		rd(`PCC_OFF_CTRL, q);
		chk(q, 32'h0000_3F00, "user write");
		rd(4'h2, q);
		chk(q, 32'h0, "unmapped read");
		$display("test access done");
	endtask

	task automatic t_freq();
		logic [31:0] q;
		int r;
		r = relocks;
		wr(`PCC_OFF_CTRL, 32'h0000_80FF);
		repeat (3) @(posedge clk);
		chk(relocks - r, 1, "relock on modulus");
		rd(`PCC_OFF_CTRL, q);
		chk(q, 32'h0000_8087, "ctrl relocking");
		chk(32'(synth), 32'h0000_0381, "synth min modulus");
		rd(`PCC_OFF_FREQ, q);
		chk(q, 32'h0020_0010, "freq w set");
		wait_lock();
		rd(`PCC_OFF_CTRL, q);
		chk(q, 32'h0000_808F, "ctrl locked");
		r = relocks;
		wr(`PCC_OFF_CTRL, 32'h0000_C087);
		repeat (3) @(posedge clk);
		chk(relocks - r, 0, "no relock on prescale");
		chk(32'(synth), 32'h0000_0301, "synth prescale");
		rd(`PCC_OFF_FREQ, q);
		chk(q, 32'h0020_0020, "freq x set");
		rd(`PCC_OFF_CTRL, q);
		chk(q, 32'h0000_C08F, "lock kept");
		$display("test freq done");
	endtask

	task automatic busclk(input int exp);
		int n;
		logic p;
		logic seen;
		n = 0;
		seen = 1'b0;
		p = pbc;
		repeat (40) begin
			@(posedge clk);
			#1;
			if (pbc === 1'b1 && p === 1'b0) begin
				if (seen) begin
					chk(n, exp, "bus clock period");
				end
				seen = 1'b1;
				n = 0;
			end
			n++;
			p = pbc;
		end
		// A stuck bus clock would otherwise leave the period unchecked.
		chk(32'(seen), 32'h1, "bus clock running");
	endtask

	task automatic t_busclk();
		repeat (20) @(posedge clk);
		busclk(16);
		wr(`PCC_OFF_CTRL, 32'h0000_C007);
		repeat (20) @(posedge clk);
		busclk(8);
		$display("test busclk done");
	endtask

	task automatic t_stop();
		for (int i = 0; i < 4; i++) begin
			wr(`PCC_OFF_CTRL, 32'h0000_C000 | i);
			@(posedge clk);
			sleep <= 1'b1;
			repeat (4) @(posedge clk);
			chk(32'(clock_output_pin_en), i & 1, "stop output");
			chk(32'(int_vco), (i >> 1) & 1, "stop integration");
			sleep <= 1'b0;
			repeat (2) @(posedge clk);
		end
		$display("test stop done");
	endtask

	task automatic t_limp();
		logic [31:0] q;
		wr(`PCC_OFF_CTRL, 32'h0000_C000);
		wr(`PCC_OFF_IRQ_MASK, 32'h1);
		ref_fail <= 1'b1;
		repeat (10) @(posedge clk);
		rd(`PCC_OFF_CTRL, q);
		chk(32'(q[4]), 32'h1, "limp flag");
		chk(32'(synth.div2_en), 32'h0, "prescale in limp");
		chk(32'(irq), 32'h1, "irq raised");
		rd(`PCC_OFF_IRQ_STATUS, q);
		chk(32'(q[0]), 32'h1, "limp status");
		wr(`PCC_OFF_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0, "irq masked");
		ref_fail <= 1'b0;
		wait_lock();
		wr(`PCC_OFF_IRQ_STATUS, 32'h7);
		rd(`PCC_OFF_IRQ_STATUS, q);
		chk(q & 32'h7, 32'h0, "status cleared");
		wr(`PCC_OFF_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0, "irq cleared");
		rd(`PCC_OFF_CTRL, q);
		chk(32'(q[4]), 32'h0, "limp cleared");
		$display("test limp done");
	endtask

	task automatic t_loss_reset();
		logic [31:0] q;
		int n;
		wr(`PCC_OFF_CTRL, 32'h0000_C004);
		ref_fail <= 1'b1;
		n = 0;
		while (sys_rstn !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk(32'(sys_rstn), 32'h0, "loss reset");
		ref_fail <= 1'b0;
		n = 0;
		while (sys_rstn !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(32'(sys_rstn), 32'h1, "out of loss reset");
		rd(`PCC_OFF_CTRL, q);
		chk(q & 32'hFFFF_FFF7, 32'h0000_3F00, "ctrl after loss");
		$display("test loss reset done");
	endtask

	task automatic t_external();
		logic [31:0] q;
		int r;
		do_reset(1'b0);
		chk(32'(synth.bypass), 32'h1, "bypass");
		chk(32'(synth.vco_en), 32'h0, "vco off");
		rd(`PCC_OFF_CTRL, q);
		chk(32'(q[3]), 32'h1, "lock flag external");
		r = relocks;
		wr(`PCC_OFF_CTRL, 32'h0000_0100);
		repeat (3) @(posedge clk);
		chk(relocks - r, 0, "no relock external");
		$display("test external done");
	endtask

	initial begin
		do_reset(1'b1);
		t_access();
		t_freq();
		t_busclk();
		t_stop();
		t_limp();
		t_loss_reset();
		t_external();
		report_and_stop();
	end
endmodule
`default_nettype wire
